// file: rtl/spsc_pkg.sv
package spsc_pkg;

  // ----------------------------------------
  // power state encoding
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    PWR_WORKING      = 3'h0,
    PWR_STOP_CLOCK   = 3'h1,
    PWR_POS          = 3'h2,
    PWR_SUSP_TO_RAM  = 3'h3,
    PWR_SUSP_TO_DISK = 3'h4
  } spsc_pwr_e;

  // ----------------------------------------
  // throttle timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  localparam int unsigned THR_RATE_W       = 8;
  localparam int unsigned THR_TICK_NS      = 1_000;
  localparam int unsigned THR_TICK_CYC     = (THR_TICK_NS * (CLK_FREQ_HZ / 1_000_000)) / 1_000;
  localparam int unsigned THR_TICK_W       = 6;

  // ----------------------------------------
  // alert routing select
  // ----------------------------------------
  localparam logic [1:0] ALERT_TO_IRQ    = 2'h0;
  localparam logic [1:0] ALERT_TO_SMI    = 2'h1;
  localparam logic [1:0] ALERT_TO_RESUME = 2'h2;

endpackage

// file: rtl/spsc_throttle.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_throttle
(
  input  wire logic                           sysClk,
  input  wire logic                           resetN,
  input  wire logic                           active,
  input  wire logic [spsc_pkg::THR_RATE_W-1:0] rate,
  output logic                                stopPhase
);
  import spsc_pkg::*;

  // ----------------------------------------
  // tick divider and phase toggle
  // ----------------------------------------
  logic [THR_TICK_W-1:0] tickCnt_q, tickCnt_d;
  logic [THR_RATE_W-1:0] rateCnt_q, rateCnt_d;
  logic                  phase_q, phase_d;
  logic                  tick;

  always_comb
  begin
    tickCnt_d = tickCnt_q;
    rateCnt_d = rateCnt_q;
    phase_d   = phase_q;
    tick      = 1'b0;
    if (!active)
    begin
      tickCnt_d = '0;
      rateCnt_d = '0;
      phase_d   = 1'b0;
    end
    else
    begin
      if (tickCnt_q == THR_TICK_W'(THR_TICK_CYC - 1))
      begin
        tickCnt_d = '0;
        tick      = 1'b1;
      end
      else
        tickCnt_d = tickCnt_q + THR_TICK_W'(1);
      if (tick)
      begin
        if (rateCnt_q >= rate)
        begin
          rateCnt_d = '0;
          phase_d   = ~phase_q;
        end
        else
          rateCnt_d = rateCnt_q + THR_RATE_W'(1);
      end
    end
  end

  always_ff @(posedge sysClk)
  begin
    if (!resetN)
    begin
      tickCnt_q <= '0;
      rateCnt_q <= '0;
      phase_q   <= 1'b0;
    end
    else
    begin
      tickCnt_q <= tickCnt_d;
      rateCnt_q <= rateCnt_d;
      phase_q   <= phase_d;
    end
  end

  assign stopPhase = phase_q;

endmodule
`default_nettype wire

// file: rtl/suspend_plane_status_control.sv
`timescale 1ns/10ps
`default_nettype none
module suspend_plane_status_control
(
  input  wire logic                           sys_clk,
  input  wire logic                           reset_n,
  input  wire logic                           suspend_well_reset_n,
  input  wire logic [2:0]                     pwrState,
  input  wire logic                           thermalEnable,
  input  wire logic [spsc_pkg::THR_RATE_W-1:0] throttleRate,
  input  wire logic                           thermal_detect_n,
  input  wire logic                           alertEnable,
  input  wire logic [1:0]                     alertRoute,
  input  wire logic                           mgmt_bus_alert_n,
  output logic                                primary_plane_ctl_n,
  output logic                                secondary_plane_ctl_n,
  output logic                                tertiary_plane_ctl_n,
  output logic                                host_clk_status_n,
  output logic                                system_suspend_status_n,
  output logic                                cpu_stop_clock_n,
  output logic                                cache_sram_sleep,
  output logic                                throttleActive,
  output logic                                alertIrq,
  output logic                                alertSmi,
  output logic                                alertResume
);
  import spsc_pkg::*;

  // ----------------------------------------
  // reset combine
  // ----------------------------------------
  logic rstN;
  assign rstN = reset_n & suspend_well_reset_n;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] thermSync_q;
  logic [1:0] thermSync_d;
  logic [1:0] alertSync_q;
  logic [1:0] alertSync_d;
  logic       alertPrev_q;
  logic       alertPrev_d;

  always_comb
  begin
    thermSync_d = {thermSync_q[0], thermal_detect_n};
    alertSync_d = {alertSync_q[0], mgmt_bus_alert_n};
    alertPrev_d = alertSync_q[1];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      thermSync_q <= 2'h3;
      alertSync_q <= 2'h3;
      alertPrev_q <= 1'b1;
    end
    else
    begin
      thermSync_q <= thermSync_d;
      alertSync_q <= alertSync_d;
      alertPrev_q <= alertPrev_d;
    end
  end

  // ----------------------------------------
  // state decode
  // ----------------------------------------
  spsc_pwr_e state;
  assign state = spsc_pwr_e'(pwrState);

  function automatic logic inSuspend(input spsc_pwr_e s);
    inSuspend = (s == PWR_POS) || (s == PWR_SUSP_TO_RAM) ||
                (s == PWR_SUSP_TO_DISK);
  endfunction

  // ----------------------------------------
  // throttle
  // ----------------------------------------
  logic thrActive;
  logic stopPhase;

  assign thrActive = thermalEnable & ~thermSync_q[1] &
                     (state == PWR_WORKING);

  spsc_throttle spsc_throttle_inst
  (
    .sysClk    (sys_clk),
    .resetN    (rstN),
    .active    (thrActive),
    .rate      (throttleRate),
    .stopPhase (stopPhase)
  );

  // ----------------------------------------
  // alert edge detect
  // ----------------------------------------
  logic alertFall;

  assign alertFall = alertPrev_q & ~alertSync_q[1];

  // ----------------------------------------
  // plane and status registers
  // ----------------------------------------
  logic prim_q;
  logic prim_d;
  logic sec_q;
  logic sec_d;
  logic ter_q;
  logic ter_d;
  logic hcs_q;
  logic hcs_d;
  logic sss_q;
  logic sss_d;

  always_comb
  begin
    prim_d = ~inSuspend(state);
    sec_d  = ~((state == PWR_SUSP_TO_RAM) ||
               (state == PWR_SUSP_TO_DISK));
    ter_d  = ~(state == PWR_SUSP_TO_DISK);
    hcs_d  = ~(inSuspend(state) || (state == PWR_STOP_CLOCK));
    sss_d  = ~inSuspend(state);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      prim_q <= 1'b0;
      sec_q  <= 1'b0;
      ter_q  <= 1'b0;
      hcs_q  <= 1'b0;
      sss_q  <= 1'b0;
    end
    else
    begin
      prim_q <= prim_d;
      sec_q  <= sec_d;
      ter_q  <= ter_d;
      hcs_q  <= hcs_d;
      sss_q  <= sss_d;
    end
  end

  // ----------------------------------------
  // clock stop and cache sleep registers
  // ----------------------------------------
  logic stp_q;
  logic stp_d;
  logic sleep_q;
  logic sleep_d;
  logic thr_q;
  logic thr_d;

  always_comb
  begin
    stp_d   = ~((state == PWR_STOP_CLOCK) || (thrActive & stopPhase));
    sleep_d = (state == PWR_STOP_CLOCK);
    thr_d   = thrActive;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      stp_q   <= 1'b1;
      sleep_q <= 1'b0;
      thr_q   <= 1'b0;
    end
    else
    begin
      stp_q   <= stp_d;
      sleep_q <= sleep_d;
      thr_q   <= thr_d;
    end
  end

  // ----------------------------------------
  // alert pulse registers
  // ----------------------------------------
  logic irq_q;
  logic irq_d;
  logic smi_q;
  logic smi_d;
  logic rsm_q;
  logic rsm_d;

  always_comb
  begin
    irq_d = alertEnable & alertFall & (alertRoute == ALERT_TO_IRQ);
    smi_d = alertEnable & alertFall & (alertRoute == ALERT_TO_SMI);
    rsm_d = alertEnable & alertFall & (alertRoute == ALERT_TO_RESUME);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      irq_q <= 1'b0;
      smi_q <= 1'b0;
      rsm_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
      smi_q <= smi_d;
      rsm_q <= rsm_d;
    end
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  assign primary_plane_ctl_n     = prim_q;
  assign secondary_plane_ctl_n   = sec_q;
  assign tertiary_plane_ctl_n    = ter_q;
  assign host_clk_status_n       = hcs_q;
  assign system_suspend_status_n = sss_q;
  assign cpu_stop_clock_n        = stp_q;
  assign cache_sram_sleep        = sleep_q;
  assign throttleActive          = thr_q;
  assign alertIrq                = irq_q;
  assign alertSmi                = smi_q;
  assign alertResume             = rsm_q;

endmodule
`default_nettype wire

// file: tb/spsc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_chk
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       suspend_well_reset_n,
  input wire logic [2:0] pwrState,
  input wire logic       primary_plane_ctl_n,
  input wire logic       secondary_plane_ctl_n,
  input wire logic       tertiary_plane_ctl_n,
  input wire logic       host_clk_status_n,
  input wire logic       system_suspend_status_n,
  input wire logic       cpu_stop_clock_n,
  input wire logic       cache_sram_sleep,
  input wire logic       throttleActive,
  input wire logic       alertIrq,
  input wire logic       alertSmi,
  input wire logic       alertResume
);
  // ----------------------------------------
  // last edge was out of reset
  // ----------------------------------------
  logic alive_q;
  always_ff @(posedge sys_clk)
  begin
    alive_q <= reset_n && suspend_well_reset_n;
  end
  default clocking @(posedge sys_clk); endclocking
  wire logic anyPulse = alertIrq | alertSmi | alertResume;
  wire logic inReset = !(reset_n && suspend_well_reset_n);
  wire logic planesLow = !primary_plane_ctl_n && !secondary_plane_ctl_n &&
                         !tertiary_plane_ctl_n && !host_clk_status_n &&
                         !system_suspend_status_n;
  a_primary_plane: assert property (
    alive_q |-> primary_plane_ctl_n ==
    !($past(pwrState) inside {3'h2, 3'h3, 3'h4})) else $error("primary");
  a_secondary_plane: assert property (
    alive_q |-> secondary_plane_ctl_n ==
    !($past(pwrState) inside {3'h3, 3'h4})) else $error("secondary");
  a_tertiary_plane: assert property (
    alive_q |-> tertiary_plane_ctl_n == ($past(pwrState) != 3'h4))
    else $error("tertiary");
  a_host_clk_stat: assert property (
    alive_q |-> host_clk_status_n ==
    !($past(pwrState) inside {3'h1, 3'h2, 3'h3, 3'h4})) else $error("host");
  a_sys_susp_stat: assert property (
    alive_q |-> system_suspend_status_n ==
    !($past(pwrState) inside {3'h2, 3'h3, 3'h4})) else $error("suspend");
  a_cache_sleep: assert property (
    alive_q |-> cache_sram_sleep == ($past(pwrState) == 3'h1))
    else $error("cache");
  a_stop_clock: assert property (
    alive_q && !throttleActive |->
    cpu_stop_clock_n == ($past(pwrState) != 3'h1)) else $error("stop clock");
  a_reset_levels: assert property (
    inReset |=> planesLow && cpu_stop_clock_n && !cache_sram_sleep &&
    !throttleActive && !anyPulse) else $error("reset levels");
  a_pulse_single: assert property (anyPulse |=> !anyPulse)
    else $error("pulse width");
  a_alert_onehot: assert property (
    anyPulse |-> $onehot({alertIrq, alertSmi, alertResume}))
    else $error("alert route");
  a_throttle_gate: assert property (
    alive_q && throttleActive |-> $past(pwrState) == 3'h0)
    else $error("throttle state");
  c_disk: cover property (alive_q && !tertiary_plane_ctl_n);
  c_throttle: cover property (throttleActive && $fell(cpu_stop_clock_n));
  c_alert: cover property (alertSmi);
  c_sleep: cover property (alive_q && cache_sram_sleep);
endmodule
`default_nettype wire

// file: tb/spsc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_far_model
(
  input  wire logic sys_clk,
  input  wire logic thermReq,
  input  wire logic alertReq,
  output var logic  thermal_detect_n,
  output var logic  mgmt_bus_alert_n
);
  // ----------------------------------------
  // sensor and alert pins, pulled high idle
  // ----------------------------------------
  initial thermal_detect_n = 1'b1;
  initial mgmt_bus_alert_n = 1'b1;
  always @(posedge sys_clk)
  begin
    thermal_detect_n <= !thermReq;
    mgmt_bus_alert_n <= !alertReq;
  end
endmodule
`default_nettype wire

// file: tb/suspend_plane_status_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module suspend_plane_status_control_tb;
  logic sys_clk = 0, reset_n = 0, suspend_well_reset_n = 0;
  logic [2:0] pwrState = 0;
  logic [7:0] throttleRate = 0;
  logic [1:0] alertRoute = 0;
  logic thermalEnable = 0, alertEnable = 0, thermReq = 0, alertReq = 0;
  logic thermal_detect_n, mgmt_bus_alert_n, primary_plane_ctl_n;
  logic secondary_plane_ctl_n, tertiary_plane_ctl_n, host_clk_status_n;
  logic system_suspend_status_n, cpu_stop_clock_n, cache_sram_sleep;
  logic throttleActive, alertIrq, alertSmi, alertResume;
  int mismatches = 0, cmp_count = 0;
  always #10 sys_clk = ~sys_clk;
  suspend_plane_status_control suspend_plane_status_control_inst (.sys_clk,
    .reset_n, .suspend_well_reset_n, .pwrState, .thermalEnable, .throttleRate,
    .thermal_detect_n, .alertEnable, .alertRoute, .mgmt_bus_alert_n,
    .primary_plane_ctl_n, .secondary_plane_ctl_n, .tertiary_plane_ctl_n,
    .host_clk_status_n, .system_suspend_status_n, .cpu_stop_clock_n,
    .cache_sram_sleep, .throttleActive, .alertIrq, .alertSmi, .alertResume);
  spsc_far_model spsc_far_model_inst (.sys_clk, .thermReq, .alertReq,
    .thermal_detect_n, .mgmt_bus_alert_n);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic t_states;
    for (int s = 0; s < 8; s++)
    begin
      @(posedge sys_clk) pwrState <= s[2:0];
      cyc(2);
      #1;
      chk(primary_plane_ctl_n, s < 2 || s > 4);
      chk(secondary_plane_ctl_n, s < 3 || s > 4);
      chk(tertiary_plane_ctl_n, s != 4);
      chk(host_clk_status_n, s == 0 || s > 4);
      chk(system_suspend_status_n, s < 2 || s > 4);
      chk(cache_sram_sleep, s == 1);
      chk(cpu_stop_clock_n, s != 1);
    end
  endtask
  task automatic t_reset;
    logic [2:0] v;
    @(posedge sys_clk)
    begin
      pwrState <= 3'h1;
      suspend_well_reset_n <= 0;
    end
    cyc(3);
    #1;
    v = {primary_plane_ctl_n, cpu_stop_clock_n, cache_sram_sleep};
    chk(v, 3'h2);
    @(posedge sys_clk) suspend_well_reset_n <= 1;
    cyc(2);
    #1;
    v = {primary_plane_ctl_n, cpu_stop_clock_n, cache_sram_sleep};
    chk(v, 3'h5);
  endtask
  task automatic t_throttle(input logic en, input logic [7:0] rate,
                            input logic [7:0] expEdges);
    int edges = 0;
    logic last;
    @(posedge sys_clk)
    begin
      pwrState <= 3'h0;
      thermalEnable <= en;
      throttleRate <= rate;
      thermReq <= 1;
    end
    last = 1'b1;
    for (int i = 0; i < 230; i++)
    begin
      @(posedge sys_clk) #1;
      if (cpu_stop_clock_n !== last) edges++;
      last = cpu_stop_clock_n;
    end
    chk(throttleActive, en);
    chk(8'(edges), expEdges);
    @(posedge sys_clk) thermReq <= 0;
    cyc(6);
    #1;
    chk({throttleActive, cpu_stop_clock_n}, 2'h1);
  endtask
  task automatic t_alert(input logic en, input logic [1:0] rt,
                         input logic [2:0] exp);
    logic [7:0] n [3] = '{0, 0, 0};
    @(posedge sys_clk)
    begin
      alertEnable <= en;
      alertRoute <= rt;
      alertReq <= 1;
    end
    repeat (14)
    begin
      @(posedge sys_clk) #1;
      n[0] += alertIrq;
      n[1] += alertSmi;
      n[2] += alertResume;
    end
    for (int k = 0; k < 3; k++) chk(n[k], exp[k]);
    @(posedge sys_clk) alertReq <= 0;
    cyc(4);
  endtask
  initial
  begin
    #100_000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    cyc(16);
    @(posedge sys_clk)
    begin
      reset_n <= 1;
      suspend_well_reset_n <= 1;
    end
    t_states;
    t_reset;
    t_throttle(1, 8'h00, 8'h04);
    t_throttle(1, 8'h01, 8'h02);
    t_throttle(0, 8'h00, 8'h00);
    for (int r = 0; r < 4; r++) t_alert(1, r[1:0], 3'h1 << r);
    t_alert(0, 2'h1, 3'h0);
    tally_and_finish;
  end
endmodule
bind suspend_plane_status_control spsc_chk spsc_chk_inst (.sys_clk,
  .reset_n, .suspend_well_reset_n, .pwrState, .primary_plane_ctl_n,
  .secondary_plane_ctl_n, .tertiary_plane_ctl_n, .host_clk_status_n,
  .system_suspend_status_n, .cpu_stop_clock_n, .cache_sram_sleep,
  .throttleActive, .alertIrq, .alertSmi, .alertResume);
`default_nettype wire
